// ===== src/sgr_pkg.sv
// sgr_pkg: register map, field positions, reset values and timing counts
// of the single-wire gauge register port.
// assumes a 200 MHz core clock; long times are derived from tick rates.
package sgr_pkg;
   // ==========================================================
   // clock and line timing
   // ==========================================================
   localparam int CLK_PERIOD_PS = 5000;
   localparam int BREAK_LOW_TIME_NS = 950;
   localparam int BREAK_RECOVERY_TIME_NS = 200;
   localparam int BIT_START_LOW_TIME_NS = 200;
   localparam int DATA_SETUP_TIME_NS = 250;
   localparam int DATA_HOLD_TIME_NS = 500;
   localparam int BIT_CYCLE_TIME_NS = 950;
   localparam int BREAK_CYC = BREAK_LOW_TIME_NS * 1000 / CLK_PERIOD_PS;
   localparam int RECOV_CYC =
      (BREAK_RECOVERY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int START_CYC =
      (BIT_START_LOW_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SETUP_CYC = DATA_SETUP_TIME_NS * 1000 / CLK_PERIOD_PS;
   localparam int HOLD_CYC = DATA_HOLD_TIME_NS * 1000 / CLK_PERIOD_PS;
   localparam int CYCLE_CYC =
      (BIT_CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // bit sample point for received bits, between setup and hold end
   localparam int SAMPLE_CYC = (SETUP_CYC + HOLD_CYC) / 2;
   // ==========================================================
   // timebase: fast time tick period 0.8789 s in microseconds
   // ==========================================================
   localparam int TIME_TICK_US = 878900;
   localparam int TIME_TICK_CYC = TIME_TICK_US * 200;
   localparam int SLOW_DIVIDE = 256;
   localparam int CAL_ENTRY_S = 10;
   localparam int CAL_HOUR_S = 3600;
   localparam int SEC_CYC = 200000000;
   // ==========================================================
   // register map
   // ==========================================================
   localparam logic [6:0] ADDR_OFFSET_VALUE = 7'h73;
   localparam logic [6:0] ADDR_TEMP_CLEAR = 7'h74;
   localparam logic [6:0] ADDR_WAKE_CONFIG = 7'h75;
   localparam logic [6:0] ADDR_CTC_LOW = 7'h76;
   localparam logic [6:0] ADDR_CTC_HIGH = 7'h77;
   localparam logic [6:0] ADDR_DTC_LOW = 7'h78;
   localparam logic [6:0] ADDR_DTC_HIGH = 7'h79;
   localparam logic [6:0] ADDR_SDC_LOW = 7'h7A;
   localparam logic [6:0] ADDR_SDC_HIGH = 7'h7B;
   localparam logic [6:0] ADDR_CCNT_LOW = 7'h7C;
   localparam logic [6:0] ADDR_CCNT_HIGH = 7'h7D;
   localparam logic [6:0] ADDR_DCNT_LOW = 7'h7E;
   localparam logic [6:0] ADDR_DCNT_HIGH = 7'h7F;
   localparam int USER_WORDS = 115;
   // wake config fields
   localparam int WK_OVERRIDE_BIT = 7;
   localparam int WK_TRIM_BIT = 6;
   localparam int WK_SLOW_CHG_BIT = 5;
   localparam int WK_SLOW_DIS_BIT = 4;
   localparam int WK_THRESH_LSB = 1;
   localparam logic [7:0] WAKE_CONFIG_RESET = 8'h0E;
   // clear register fields
   localparam int CLR_CTC_BIT = 4;
   localparam int CLR_DTC_BIT = 3;
   localparam int CLR_SDC_BIT = 2;
   localparam int CLR_CCNT_BIT = 1;
   localparam int CLR_DCNT_BIT = 0;
   localparam int TEMP_LSB = 5;
   localparam int CMD_DIR_BIT = 7;
endpackage

// ===== src/sgr_line_if.sv
// sgr_line_if: byte level handshake between the line engine and the map.
// assumes both ends run on the core clock.
`timescale 1ns/1ps
interface sgr_line_if;
   logic cmd_valid;
   logic [7:0] cmd_byte;
   logic data_valid;
   logic [7:0] data_byte;
   logic [7:0] read_byte;
   logic break_seen;
   modport engine (output cmd_valid, output cmd_byte, output data_valid,
      output data_byte, output break_seen, input read_byte);
   modport regs (input cmd_valid, input cmd_byte, input data_valid,
      input data_byte, input break_seen, output read_byte);
endinterface

// ===== src/sgr_line_engine.sv
// sgr_line_engine: return-to-one bit framing on the single data line,
// break detection, command byte reception and byte send or receive.
// assumes the line input is already synchronised to the core clock.
`timescale 1ns/1ps
module sgr_line_engine
   import sgr_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic line_in,
   output logic line_drive_low,
   sgr_line_if.engine bus
);
   typedef enum logic [4:0] {
      ST_RECOVER = 5'b00001,
      ST_RXBIT = 5'b00010,
      ST_TXBIT = 5'b00100,
      ST_WAIT_HIGH = 5'b01000,
      ST_TXGAP = 5'b10000
   } sgr_eng_e;
   sgr_eng_e state;
   logic [31:0] cnt;
   logic [31:0] low_cnt;
   logic [2:0] bit_idx;
   logic [7:0] shift;
   logic phase_data;
   logic [7:0] tx_byte;
   logic line_q;
   logic bit_val;
   wire fall = line_q && !line_in;
   wire is_break = low_cnt >= 32'(BREAK_CYC);
   wire last_bit = bit_idx == 3'h7;
   wire [7:0] next_shift = {bit_val, shift[7:1]};
   always_ff @(posedge core_clk_in) begin
      line_q <= line_in;
      if (line_in)
         low_cnt <= '0;
      else if (!is_break)
         low_cnt <= low_cnt + 32'h1;
   end
   always_ff @(posedge core_clk_in) begin
      bus.cmd_valid <= 1'b0;
      bus.data_valid <= 1'b0;
      bus.break_seen <= 1'b0;
      if (srst_in) begin
         state <= ST_RECOVER;
         cnt <= '0;
         bit_idx <= '0;
         shift <= '0;
         phase_data <= 1'b0;
         tx_byte <= '0;
         bit_val <= 1'b0;
         line_drive_low <= 1'b0;
         bus.cmd_byte <= '0;
         bus.data_byte <= '0;
      end else if (is_break && state != ST_RECOVER) begin
         // break from any state other than ST_RECOVER resynchronises the line
         state <= ST_RECOVER;
         line_drive_low <= 1'b0;
         bus.break_seen <= 1'b1;
         cnt <= '0;
      end else begin
         case (state)
            ST_RECOVER: begin
               // line must stand high for the recovery time
               cnt <= line_in ? cnt + 32'h1 : '0;
               if (line_in && cnt >= 32'(RECOV_CYC)) begin
                  state <= ST_WAIT_HIGH;
                  bit_idx <= '0;
                  phase_data <= 1'b0;
               end
            end
            ST_WAIT_HIGH: begin
               cnt <= '0;
               if (fall) state <= ST_RXBIT;
            end
            ST_RXBIT: begin
               cnt <= cnt + 32'h1;
               if (cnt == 32'(SAMPLE_CYC)) bit_val <= line_in;
               if (cnt > 32'(SAMPLE_CYC) && line_in) begin
                  shift <= next_shift;
                  bit_idx <= bit_idx + 3'h1;
                  state <= ST_WAIT_HIGH;
                  if (last_bit && !phase_data) begin
                     // eight contiguous bits load the command
                     bus.cmd_byte <= next_shift;
                     bus.cmd_valid <= 1'b1;
                     if (next_shift[CMD_DIR_BIT]) begin
                        phase_data <= 1'b1;
                     end else begin
                        state <= ST_TXGAP;
                        cnt <= '0;
                     end
                  end else if (last_bit) begin
                     bus.data_byte <= next_shift;
                     bus.data_valid <= 1'b1;
                     phase_data <= 1'b0;
                  end
               end
            end
            ST_TXGAP: begin
               cnt <= cnt + 32'h1;
               if (cnt == 32'(CYCLE_CYC)) begin
                  tx_byte <= bus.read_byte;
                  bit_idx <= '0;
                  cnt <= '0;
                  state <= ST_TXBIT;
               end
            end
            ST_TXBIT: begin
               // start low, data, then high until cycle end
               cnt <= cnt + 32'h1;
               line_drive_low <= (cnt < 32'(START_CYC)) ||
                  (cnt < 32'(HOLD_CYC) && !tx_byte[bit_idx]);
               if (cnt == 32'(CYCLE_CYC)) begin
                  cnt <= '0;
                  bit_idx <= bit_idx + 3'h1;
                  if (last_bit) state <= ST_WAIT_HIGH;
               end
            end
            default: state <= ST_RECOVER;
         endcase
      end
   end
endmodule

// ===== src/sgr_gauge_port.sv
// sgr_gauge_port: register map, counters and offset calibration of the
// single-wire gauge, behind the single data line.
// assumes sense and temperature levels come from asynchronous logic.
`timescale 1ns/1ps
//
// Contract
// - written clear bit zeroes its pair then self-clears without host action.
// - discharge time clear also clears its slow flag and fast rate.
// - charge time clear also clears its slow flag and fast rate.
// - trim request arms calibration; entry after line low over 10 s.
// - one hour low and quiet latches offset and clears trim request.
// - after calibration stay in low power until the line goes high.
// - line high or signal above threshold restarts cycle; request kept.
// - override ignores line level; override clears at valid calibration end.
// - each transaction is a command byte then one data byte.
// - bytes travel lsb first with return-to-one bit framing.
// - break is long low then high recovery before a new command.
// - each bit starts low, data valid, then high until cycle end.
// - command taken only after eight contiguous bits; it is write-only.
// - command msb zero reads, one writes the next byte.
// - lower seven command bits address offsets 00 to 7f.
// - discharge count increments on discharge and wraps past ffff.
// - charge count increments on charge and wraps; host clears it.
// - wake config bit 0 reads zero and ignores writes.
// - wake config resets to 0e.
// - first time counter rollover sets slow flag, rate drops to 1/256; a second rollover clears it.
// - clear bits map ctc, dtc, self, charge count, discharge count.
// - clear register bits 7 to 5 report the temperature step.
module sgr_gauge_port
   import sgr_pkg::*;
#(
   parameter int TIME_TICK = TIME_TICK_CYC,
   parameter int SEC_TICK = SEC_CYC,
   parameter int HOUR_SECS = CAL_HOUR_S
)(
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic host_data_line_in,
   input wire logic discharge_sense_in,
   input wire logic charge_sense_in,
   input wire logic above_wake_threshold_in,
   input wire logic count_pulse_in,
   input wire logic self_discharge_pulse_in,
   input wire logic [2:0] temperature_step_field_in,
   input wire logic [7:0] input_offset_voltage_in,
   output logic host_data_line_out,
   output logic host_data_line_oe_out,
   output logic wake_active_out,
   output logic sleep_out,
   output logic [2:0] wake_threshold_select_out
);
   import sgr_pkg::*;
   // ==========================================================
   // input synchronisers
   // ==========================================================
   localparam int NSYNC = 16;
   logic [NSYNC-1:0] sync_a;
   logic [NSYNC-1:0] sync_b;
   wire [NSYNC-1:0] raw_in = {host_data_line_in, discharge_sense_in,
      charge_sense_in, above_wake_threshold_in, count_pulse_in,
      self_discharge_pulse_in, temperature_step_field_in,
      input_offset_voltage_in[7:1]};
   always_ff @(posedge core_clk_in) begin
      sync_a <= raw_in;
      sync_b <= sync_a;
   end
   wire line_s = sync_b[15];
   wire dis_s = sync_b[14];
   wire chg_s = sync_b[13];
   wire above_s = sync_b[12];
   wire cnt_s = sync_b[11];
   wire sdc_s = sync_b[10];
   wire [2:0] temp_s = sync_b[9:7];
   wire [7:0] ofs_s = {sync_b[6:0], 1'b0};
   logic [7:0] ofs_q;
   logic cnt_q;
   logic sdc_q;
   always_ff @(posedge core_clk_in) begin
      cnt_q <= cnt_s;
      sdc_q <= sdc_s;
   end
   // ==========================================================
   // line engine
   // ==========================================================
   sgr_line_if lif();
   logic drive_low;
   sgr_line_engine u_engine (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .line_in(line_s),
      .line_drive_low(drive_low),
      .bus(lif.engine)
   );
   // ==========================================================
   // register state
   // ==========================================================
   logic [7:0] user_mem [USER_WORDS];
   logic [7:0] offset_value;
   logic [7:0] wake_config_register;
   logic [4:0] clear_bits;
   logic [15:0] charge_time_counter;
   logic [15:0] discharge_time_counter;
   logic [15:0] self_discharge_counter;
   logic [15:0] charge_count;
   logic [15:0] discharge_count;
   logic [6:0] wr_addr;
   logic sleeping;
   wire [6:0] target_address_field = lif.cmd_byte[6:0];
   wire wr_hit = lif.data_valid;
   wire slow_chg = wake_config_register[WK_SLOW_CHG_BIT];
   wire slow_dis = wake_config_register[WK_SLOW_DIS_BIT];
   wire cal_armed = wake_config_register[WK_TRIM_BIT];
   wire override = wake_config_register[WK_OVERRIDE_BIT];
   // ==========================================================
   // timebase
   // ==========================================================
   logic [31:0] tick_cnt;
   logic [7:0] slow_chg_div;
   logic [7:0] slow_dis_div;
   wire fast_tick = tick_cnt == 32'(TIME_TICK - 1);
   always_ff @(posedge core_clk_in) begin
      if (srst_in || fast_tick)
         tick_cnt <= '0;
      else
         tick_cnt <= tick_cnt + 32'h1;
   end
   wire run = !sleeping;
   wire ctc_step = run && chg_s && fast_tick &&
      (!slow_chg || slow_chg_div == 8'(SLOW_DIVIDE - 1));
   wire dtc_step = run && dis_s && fast_tick &&
      (!slow_dis || slow_dis_div == 8'(SLOW_DIVIDE - 1));
   wire cnt_rise = cnt_s && !cnt_q;
   wire dcount_step = run && dis_s && cnt_rise;
   wire ccount_step = run && chg_s && cnt_rise;
   wire sdc_step = run && sdc_s && !sdc_q;
   // ==========================================================
   // clear register
   // ==========================================================
   wire clr_wr = wr_hit && wr_addr == ADDR_TEMP_CLEAR;
   wire [4:0] clr_now = clear_bits;
   always_ff @(posedge core_clk_in) begin
      if (srst_in)
         clear_bits <= '0;
      else if (clr_wr)
         clear_bits <= lif.data_byte[4:0];
      else
         clear_bits <= '0;
   end
   // ==========================================================
   // counters
   // ==========================================================
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         charge_time_counter <= '0;
         discharge_time_counter <= '0;
         self_discharge_counter <= '0;
         charge_count <= '0;
         discharge_count <= '0;
         slow_chg_div <= '0;
         slow_dis_div <= '0;
      end else begin
         if (clr_now[CLR_CTC_BIT]) begin
            charge_time_counter <= '0;
            slow_chg_div <= '0;
         end else if (run && chg_s && fast_tick) begin
            slow_chg_div <= slow_chg_div + 8'h1;
            if (ctc_step) charge_time_counter <= charge_time_counter + 16'h1;
         end
         if (clr_now[CLR_DTC_BIT]) begin
            discharge_time_counter <= '0;
            slow_dis_div <= '0;
         end else if (run && dis_s && fast_tick) begin
            slow_dis_div <= slow_dis_div + 8'h1;
            if (dtc_step)
               discharge_time_counter <= discharge_time_counter + 16'h1;
         end
         if (clr_now[CLR_SDC_BIT])
            self_discharge_counter <= '0;
         else if (sdc_step)
            self_discharge_counter <= self_discharge_counter + 16'h1;
         if (clr_now[CLR_CCNT_BIT])
            charge_count <= '0;
         else if (ccount_step)
            charge_count <= charge_count + 16'h1;
         if (clr_now[CLR_DCNT_BIT])
            discharge_count <= '0;
         else if (dcount_step)
            discharge_count <= discharge_count + 16'h1;
      end
   end
   // ==========================================================
   // calibration sequencer
   // ==========================================================
   typedef enum logic [3:0] {
      CAL_IDLE = 4'b0001,
      CAL_ENTRY = 4'b0010,
      CAL_MEASURE = 4'b0100,
      CAL_DONE = 4'b1000
   } sgr_cal_e;
   sgr_cal_e cal_state;
   logic [31:0] sec_cnt;
   logic [15:0] secs;
   wire sec_tick = sec_cnt == 32'(SEC_TICK - 1);
   wire line_ok = override || !line_s;
   wire cal_cond = cal_armed && line_ok && !above_s;
   wire cal_finish = cal_state == CAL_MEASURE && sec_tick &&
      secs == 16'(HOUR_SECS - 1) && cal_cond;
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         cal_state <= CAL_IDLE;
         sec_cnt <= '0;
         secs <= '0;
         ofs_q <= '0;
         sleeping <= 1'b0;
      end else begin
         sec_cnt <= sec_tick ? '0 : sec_cnt + 32'h1;
         ofs_q <= ofs_s;
         case (cal_state)
            CAL_IDLE: begin
               secs <= '0;
               if (cal_cond) cal_state <= CAL_ENTRY;
            end
            CAL_ENTRY: begin
               if (!cal_cond)
                  cal_state <= CAL_IDLE;
               else if (sec_tick) begin
                  secs <= secs + 16'h1;
                  if (secs == 16'(CAL_ENTRY_S)) begin
                     cal_state <= CAL_MEASURE;
                     secs <= '0;
                  end
               end
            end
            CAL_MEASURE: begin
               if (!cal_cond)
                  cal_state <= CAL_IDLE;
               else if (cal_finish)
                  cal_state <= CAL_DONE;
               else if (sec_tick)
                  secs <= secs + 16'h1;
            end
            CAL_DONE: begin
               if (line_s) cal_state <= CAL_IDLE;
            end
            default: cal_state <= CAL_IDLE;
         endcase
         sleeping <= cal_state == CAL_DONE && !line_s;
      end
   end
   // ==========================================================
   // writable registers
   // ==========================================================
   wire wk_wr = wr_hit && wr_addr == ADDR_WAKE_CONFIG;
   wire ofs_wr = wr_hit && wr_addr == ADDR_OFFSET_VALUE;
   wire mem_wr = wr_hit && wr_addr < ADDR_OFFSET_VALUE;
   wire chg_roll = ctc_step && charge_time_counter == 16'hFFFF;
   wire dis_roll = dtc_step && discharge_time_counter == 16'hFFFF;
   logic [7:0] next_wake;
   always_comb begin
      next_wake = wake_config_register;
      if (wk_wr) next_wake = {lif.data_byte[7:6], next_wake[5:4],
         lif.data_byte[3:1], 1'b0};
      if (clr_now[CLR_CTC_BIT]) next_wake[WK_SLOW_CHG_BIT] = 1'b0;
      if (clr_now[CLR_DTC_BIT]) next_wake[WK_SLOW_DIS_BIT] = 1'b0;
      // second rollover clears the flag again
      if (chg_roll) next_wake[WK_SLOW_CHG_BIT] = !slow_chg;
      if (dis_roll) next_wake[WK_SLOW_DIS_BIT] = !slow_dis;
      if (cal_finish) begin
         next_wake[WK_TRIM_BIT] = 1'b0;
         next_wake[WK_OVERRIDE_BIT] = 1'b0;
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         wake_config_register <= WAKE_CONFIG_RESET;
         offset_value <= '0;
         wr_addr <= '0;
      end else begin
         wake_config_register <= next_wake;
         if (lif.cmd_valid) wr_addr <= target_address_field;
         if (cal_finish)
            offset_value <= ofs_q;
         else if (ofs_wr)
            offset_value <= lif.data_byte;
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (mem_wr) user_mem[wr_addr] <= lif.data_byte;
   end
   // ==========================================================
   // read mux
   // ==========================================================
   logic [7:0] rd_mux;
   always_comb begin
      case (target_address_field)
         ADDR_OFFSET_VALUE: rd_mux = offset_value;
         ADDR_TEMP_CLEAR: rd_mux = {temp_s, clear_bits};
         ADDR_WAKE_CONFIG: rd_mux = wake_config_register;
         ADDR_CTC_LOW: rd_mux = charge_time_counter[7:0];
         ADDR_CTC_HIGH: rd_mux = charge_time_counter[15:8];
         ADDR_DTC_LOW: rd_mux = discharge_time_counter[7:0];
         ADDR_DTC_HIGH: rd_mux = discharge_time_counter[15:8];
         ADDR_SDC_LOW: rd_mux = self_discharge_counter[7:0];
         ADDR_SDC_HIGH: rd_mux = self_discharge_counter[15:8];
         ADDR_CCNT_LOW: rd_mux = charge_count[7:0];
         ADDR_CCNT_HIGH: rd_mux = charge_count[15:8];
         ADDR_DCNT_LOW: rd_mux = discharge_count[7:0];
         ADDR_DCNT_HIGH: rd_mux = discharge_count[15:8];
         default: rd_mux = user_mem[target_address_field];
      endcase
   end
   assign lif.read_byte = rd_mux;
   // ==========================================================
   // outputs
   // ==========================================================
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         host_data_line_out <= 1'b0;
         host_data_line_oe_out <= 1'b0;
         wake_active_out <= 1'b0;
         sleep_out <= 1'b0;
         wake_threshold_select_out <= 3'h7;
      end else begin
         host_data_line_out <= 1'b0;
         host_data_line_oe_out <= drive_low;
         wake_active_out <= above_s;
         sleep_out <= sleeping;
         wake_threshold_select_out <= wake_config_register[3:1];
      end
   end
endmodule

// ===== verification/sgr_gauge_port_chk.sv
// sgr_gauge_port_chk: line and power checks at the gauge port pins.
// assumes bind to sgr_gauge_port with the package line timing.
`timescale 1ns/1ps
module sgr_gauge_port_chk
   import sgr_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic host_data_line_in,
   input wire logic host_data_line_out,
   input wire logic host_data_line_oe_out,
   input wire logic sleep_out,
   input wire logic [2:0] wake_threshold_select_out
);
   // =====================================
   // helper counters
   int low_len;
   int gap;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (srst_in);
   always_ff @(posedge core_clk_in) begin
      low_len <= host_data_line_oe_out ? low_len + 1 : 0;
      gap <= (srst_in || $rose(host_data_line_oe_out)) ? 0 : gap + 1;
   end
   // =====================================
   // assertions
   line_out_low_a: assert property (!host_data_line_out)
      else $error("line data output not low");
   thresh_reset_a: assert property ($past(srst_in) |->
      wake_threshold_select_out == 3'h7) else $error("threshold reset");
   bit_low_len_a: assert property ($fell(host_data_line_oe_out) |->
      low_len inside {[START_CYC - 1:HOLD_CYC]}) else $error("bit low");
   bit_spacing_a: assert property ($rose(host_data_line_oe_out) |->
      gap >= CYCLE_CYC - 1) else $error("bits too close");
   no_clash_a: assert property ($rose(host_data_line_oe_out) |->
      $past(host_data_line_in)) else $error("drive on low line");
   sleep_wakes_a: assert property (sleep_out &&
      $rose(host_data_line_in) |-> ##[1:8] !sleep_out)
      else $error("sleep kept");
   sleep_silent_a: assert property (sleep_out |->
      !host_data_line_oe_out) else $error("drive in sleep");
   sleep_holds_a: assert property (sleep_out &&
      !host_data_line_in |=> sleep_out) else $error("sleep left early");
   cover property ($rose(sleep_out));
   cover property ($fell(host_data_line_oe_out));
   cover property ($rose(host_data_line_oe_out) && gap > CYCLE_CYC);
endmodule
bind sgr_gauge_port sgr_gauge_port_chk sgr_gauge_port_chk_i (.core_clk_in,
   .srst_in, .host_data_line_in, .host_data_line_out, .host_data_line_oe_out,
   .sleep_out, .wake_threshold_select_out);

// ===== verification/sgr_host_model.sv
// sgr_host_model: host end of the single data line, open drain.
// assumes the bench resolves the line with a pull-up.
`timescale 1ns/1ps
module sgr_host_model
   import sgr_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic line_in,
   output logic host_low_out
);
   initial host_low_out = 1'b0;
   task automatic wait_clk(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask
   task automatic send_bit(input logic b);
      host_low_out <= 1'b1;
      wait_clk(b ? START_CYC : HOLD_CYC);
      host_low_out <= 1'b0;
      wait_clk(CYCLE_CYC - (b ? START_CYC : HOLD_CYC));
   endtask
   task automatic hold_low(input logic l);
      host_low_out <= l;
   endtask
   task automatic send_byte(input logic [7:0] v);
      for (int i = 0; i < 8; i++) send_bit(v[i]);
   endtask
   task automatic send_break();
      host_low_out <= 1'b1;
      wait_clk(BREAK_CYC + 10);
      host_low_out <= 1'b0;
      wait_clk(RECOV_CYC + 10);
   endtask
   task automatic recv_byte(output logic [7:0] v);
      int n;
      for (int i = 0; i < 8; i++) begin
         n = 0;
         while (line_in === 1'b1 && n < 3 * CYCLE_CYC) begin
            wait_clk(1);
            n++;
         end
         wait_clk(SAMPLE_CYC);
         v[i] = line_in;
         wait_clk(HOLD_CYC - SAMPLE_CYC + 10);
      end
      wait_clk(CYCLE_CYC);
   endtask
endmodule

// ===== verification/test_single_wire_gauge_register_port.sv
// test_single_wire_gauge_register_port: register access over the line.
// assumes shortened timebase parameters on the design.
`timescale 1ns/1ps
module test_single_wire_gauge_register_port;
   import sgr_pkg::*;
   logic core_clk_in, srst_in, dis, chg, above, pulse;
   logic [2:0] temp, thr;
   logic [7:0] ofs, v;
   logic dout, oe, wake, sleep, host_low;
   wire logic line = ~(oe | host_low);
   int err_count = 0;
   int compares = 0;
   sgr_gauge_port #(.TIME_TICK(100), .SEC_TICK(100), .HOUR_SECS(4))
      sgr_gauge_port_i (.core_clk_in, .srst_in, .host_data_line_in(line),
      .discharge_sense_in(dis), .charge_sense_in(chg),
      .above_wake_threshold_in(above), .count_pulse_in(pulse),
      .self_discharge_pulse_in(1'b0), .temperature_step_field_in(temp),
      .input_offset_voltage_in(ofs), .host_data_line_out(dout),
      .host_data_line_oe_out(oe), .wake_active_out(wake),
      .sleep_out(sleep), .wake_threshold_select_out(thr));
   sgr_host_model sgr_host_model_i (.core_clk_in, .line_in(line),
      .host_low_out(host_low));
   // =====================================
   // shared tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      sgr_host_model_i.send_byte({1'b1, a});
      sgr_host_model_i.send_byte(d);
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      sgr_host_model_i.send_byte({1'b0, a});
      sgr_host_model_i.recv_byte(d);
   endtask
   task automatic print_verdict();
      if (err_count == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // =====================================
   // scenarios
   task automatic t_map();
      rd(ADDR_WAKE_CONFIG, v);
      check(v, WAKE_CONFIG_RESET);
      check({5'h0, thr}, 8'h07);
      above <= 1'b1;
      repeat (6) @(posedge core_clk_in);
      check({7'h0, wake}, 8'h01);
      above <= 1'b0;
      wr(ADDR_OFFSET_VALUE, 8'hA5);
      rd(ADDR_OFFSET_VALUE, v);
      check(v, 8'hA5);
   endtask
   task automatic t_count();
      dis <= 1'b1;
      repeat (3) begin
         pulse <= 1'b1;
         repeat (6) @(posedge core_clk_in);
         pulse <= 1'b0;
         repeat (6) @(posedge core_clk_in);
      end
      dis <= 1'b0;
      rd(ADDR_DCNT_LOW, v);
      check(v, 8'h03);
      wr(ADDR_DCNT_LOW, 8'hFF);
      rd(ADDR_DCNT_LOW, v);
      check(v, 8'h03);
      wr(ADDR_TEMP_CLEAR, 8'h01);
      rd(ADDR_TEMP_CLEAR, v);
      check(v, 8'hA0);
      rd(ADDR_DCNT_LOW, v);
      check(v, 8'h00);
   endtask
   task automatic t_cal();
      wr(ADDR_WAKE_CONFIG, 8'h4E);
      sgr_host_model_i.hold_low(1'b1);
      repeat (3000) @(posedge core_clk_in);
      check({7'h0, sleep}, 8'h01);
      sgr_host_model_i.hold_low(1'b0);
      repeat (20) @(posedge core_clk_in);
      check({7'h0, sleep}, 8'h00);
      sgr_host_model_i.send_break();
      rd(ADDR_OFFSET_VALUE, v);
      check(v, 8'h5A);
      rd(ADDR_WAKE_CONFIG, v);
      check(v, WAKE_CONFIG_RESET);
   endtask
   initial begin
      core_clk_in = 1'b0;
      forever #2.5 core_clk_in = ~core_clk_in;
   end
   initial begin
      repeat (90000) @(posedge core_clk_in);
      err_count++;
      print_verdict();
   end
   initial begin
      {srst_in, dis, chg, above, pulse, temp, ofs} = {5'b10000, 3'h5, 8'h5A};
      repeat (12) @(posedge core_clk_in);
      srst_in <= 1'b0;
      repeat (RECOV_CYC) @(posedge core_clk_in);
      sgr_host_model_i.send_break();
      t_map();
      t_count();
      t_cal();
      print_verdict();
   end
endmodule
